// File: mlt_access.sv
/*
 * Indirect access engine for the address lookup table: hashed and
 * direct single reads and writes, and a sequential search that hands
 * out each live entry through the entry data registers.
 * Assumes the register port is synchronous to core_clk and that the
 * hash option input is stable while an operation runs.
 */
// What this block does
// - Direct mode takes the 12-bit slot from address bits 11:0.
// - Operation code 10 performs a single-entry read.
// - Direct-select bit picks hashed or direct slot for reads, writes.
// - Host sets go_done_flag to start; device clears it when done.
// - After a hashed read, valid flag tells whether a matching entry was found; after a direct read, whether the slot is live.
// - entry_or_end_flag is high on a new valid entry or on finish.
// - A read that misses leaves all entry data words zero.
// - Search walks the whole table and shows only live entries.
// - Operation code 11 performs a sequential search.
// - A search starts from the first table slot.
// - Search clears valid at start, sets it on each found entry.
// - Reading entry word four resumes the search for the next entry.
// - During a search go_done_flag holds until all entries are returned.
// - Writing go_done_flag low aborts a running search.
// - After the search ends, entry data words read zero.
// - found_entry_tally counts live entries found by the search.
// - Operation code 01 writes entry data into the selected slot.
// - Word one bits 31..29: static, source drop, destination drop.
// - Bits 28:26 hold priority or aging_counter; dynamic dead at zero.
// - Word one bits 2:0 hold the spanning group identifier.
// - All entries readable; only static entries are ever written.
// - Table is 1K buckets of four ways, 10-bit bucket hash.
// - Word three holds group id and high address; word four low address.
`timescale 1ns/10ps
`default_nettype none
module mlt_access import mlt_pkg::*; #(
   parameter int DEPTH = TABLE_DEPTH,
   parameter int WAYS = BUCKET_WAYS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Lookup configuration
   input wire logic hash_use_fid
);
   localparam int IW = $clog2(DEPTH);
   localparam int WW = $clog2(WAYS);
   localparam int BW = IW - WW;
   localparam int TW = IW + 1;

   typedef enum logic [1:0] {ST_IDLE, ST_PROBE, ST_SCAN, ST_HOLD} mlt_state_t;

   mlt_state_t state;
   logic go_done;
   logic valid_q;
   logic direct_q;
   logic [1:0] op_q;
   logic [TW-1:0] tally;
   mlt_key_t key_q;
   mlt_entry_t entry_q;
   mlt_entry_t cur;
   mlt_entry_t load_val;
   logic [WW-1:0] way;
   logic [WW-1:0] free_way;
   logic [WW-1:0] dyn_way;
   logic free_found;
   logic dyn_found;
   logic [IW-1:0] scan_ptr;
   logic [IW-1:0] probe_idx;
   logic [IW-1:0] rd_idx;
   logic [IW-1:0] wr_idx;
   logic [BW-1:0] bucket;
   logic [1:0] wr_op;
   logic wr_ctrl;
   logic start_cmd;
   logic abort_cmd;
   logic tail_read;
   logic host_data_wr;
   logic cur_live;
   logic cur_match;
   logic last_way;
   logic last_ptr;
   logic mem_we;
   logic load_en;
   logic op_end;
   logic hit;
   logic entry_or_end_flag;
   logic [31:0] rd_word;

   assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
   assign wr_op = reg_wdata[CTRL_OP_HI:CTRL_OP_LO];
   assign start_cmd = wr_ctrl && reg_wdata[CTRL_GO] && state == ST_IDLE
      && wr_op != OP_NONE;
   assign abort_cmd = wr_ctrl && !reg_wdata[CTRL_GO] && op_q == OP_SEARCH
      && (state == ST_SCAN || state == ST_HOLD);
   assign tail_read = reg_rd && reg_addr == OFS_ENTRY4;
   // Data registers are frozen while the engine owns them
   assign host_data_wr = reg_wr && state == ST_IDLE;

   mlt_hash #(.OUT_W(BW)) u_hash (
      .key(key_q),
      .use_fid(hash_use_fid),
      .bucket(bucket)
   );

   assign probe_idx = direct_q ? key_q.mac[IW-1:0] : {bucket, way};
   assign rd_idx = (state == ST_SCAN || state == ST_HOLD) ? scan_ptr
      : probe_idx;

   mlt_store #(.WIDTH($bits(mlt_entry_t)), .DEPTH(DEPTH), .AW(IW)) u_store (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(mem_we),
      .wr_idx(wr_idx),
      .wr_data(entry_q),
      .rd_idx(rd_idx),
      .rd_data(cur)
   );

   assign cur_live = mlt_live(cur);
   assign cur_match = cur_live && cur.mac == key_q.mac
      && (!hash_use_fid || cur.forwarding_group_id == key_q.forwarding_group_id);
   assign last_way = way == WW'(WAYS - 1);
   assign last_ptr = scan_ptr == IW'(DEPTH - 1);

   // Engine decisions for the current cycle
   always_comb begin
      load_en = 1'b0;
      load_val = '0;
      mem_we = 1'b0;
      wr_idx = probe_idx;
      op_end = 1'b0;
      hit = 1'b0;
      case (state)
         ST_PROBE: begin
            if (op_q == OP_READ) begin
               if (direct_q || cur_match || last_way) begin
                  op_end = 1'b1;
                  load_en = 1'b1;
                  hit = direct_q ? cur_live : cur_match;
                  load_val = hit ? cur : '0;
               end
            end else if (direct_q || cur_match) begin
               op_end = 1'b1;
               mem_we = entry_q.stat;
            end else if (last_way) begin
               op_end = 1'b1;
               if (free_found || !cur_live) begin
                  mem_we = entry_q.stat;
                  wr_idx = {bucket, free_found ? free_way : way};
               end else if (dyn_found || !cur.stat) begin
                  // Full bucket gives up a dynamic entry, never a static one
                  mem_we = entry_q.stat;
                  wr_idx = {bucket, dyn_found ? dyn_way : way};
               end
            end
         end
         ST_SCAN: begin
            if (cur_live) begin
               load_en = 1'b1;
               load_val = cur;
            end else if (last_ptr) begin
               load_en = 1'b1;
            end
         end
         ST_HOLD: begin
            load_en = tail_read && last_ptr && !abort_cmd;
         end
         default: begin
            load_en = 1'b0;
         end
      endcase
   end

   // Sequencing of probes and scan position
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         way <= '0;
         scan_ptr <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_cmd) begin
                  way <= '0;
                  scan_ptr <= '0;
                  state <= (wr_op == OP_SEARCH) ? ST_SCAN : ST_PROBE;
               end
            end
            ST_PROBE: begin
               if (op_end) begin
                  state <= ST_IDLE;
               end else begin
                  way <= way + WW'(1);
               end
            end
            ST_SCAN: begin
               if (abort_cmd) begin
                  state <= ST_IDLE;
               end else if (cur_live) begin
                  state <= ST_HOLD;
               end else if (last_ptr) begin
                  state <= ST_IDLE;
               end else begin
                  scan_ptr <= scan_ptr + IW'(1);
               end
            end
            ST_HOLD: begin
               if (abort_cmd) begin
                  state <= ST_IDLE;
               end else if (tail_read) begin
                  if (last_ptr) begin
                     state <= ST_IDLE;
                  end else begin
                     scan_ptr <= scan_ptr + IW'(1);
                     state <= ST_SCAN;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Replacement candidates seen while probing a bucket
   always_ff @(posedge core_clk) begin
      if (rst || start_cmd) begin
         free_found <= 1'b0;
         dyn_found <= 1'b0;
         free_way <= '0;
         dyn_way <= '0;
      end else if (state == ST_PROBE) begin
         if (!cur_live && !free_found) begin
            free_found <= 1'b1;
            free_way <= way;
         end
         if (cur_live && !cur.stat && !dyn_found) begin
            dyn_found <= 1'b1;
            dyn_way <= way;
         end
      end
   end

   // Control and status flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         go_done <= 1'b0;
         valid_q <= 1'b0;
         op_q <= OP_NONE;
         direct_q <= 1'b0;
         tally <= '0;
      end else begin
         if (start_cmd) begin
            go_done <= 1'b1;
            op_q <= wr_op;
            direct_q <= reg_wdata[CTRL_DIRECT];
            valid_q <= 1'b0;
            if (wr_op == OP_SEARCH) begin
               tally <= '0;
            end
         end else if (wr_ctrl && state == ST_IDLE) begin
            op_q <= wr_op;
            direct_q <= reg_wdata[CTRL_DIRECT];
         end
         if (abort_cmd) begin
            go_done <= 1'b0;
         end else if (state == ST_PROBE && op_end) begin
            go_done <= 1'b0;
            valid_q <= hit;
         end else if (state == ST_SCAN) begin
            if (cur_live) begin
               valid_q <= 1'b1;
               tally <= tally + TW'(1);
            end else if (last_ptr) begin
               go_done <= 1'b0;
            end
         end else if (state == ST_HOLD && tail_read) begin
            valid_q <= 1'b0;
            if (last_ptr) begin
               go_done <= 1'b0;
            end
         end
      end
   end

   assign entry_or_end_flag = valid_q | !go_done;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_q <= '0;
      end else if (host_data_wr && reg_addr == OFS_INDEX0) begin
         key_q.forwarding_group_id <= reg_wdata[W3_FID_LO +: 7];
         key_q.mac[47:32] <= reg_wdata[W3_MAC_LO +: 16];
      end else if (host_data_wr && reg_addr == OFS_INDEX1) begin
         key_q.mac[31:0] <= reg_wdata;
      end
   end

   // Entry data words
   always_ff @(posedge core_clk) begin
      if (rst) begin
         entry_q <= '0;
      end else if (load_en) begin
         entry_q <= load_val;
      end else if (host_data_wr) begin
         case (reg_addr)
            OFS_ENTRY1: begin
               entry_q.stat <= reg_wdata[W1_STATIC];
               entry_q.src_drop <= reg_wdata[W1_SRC_DROP];
               entry_q.dst_drop <= reg_wdata[W1_DST_DROP];
               entry_q.prio_age <= reg_wdata[W1_AGE_LO +: 3];
               entry_q.span_id <= reg_wdata[W1_SPAN_LO +: 3];
            end
            OFS_ENTRY2: begin
               entry_q.override <= reg_wdata[W2_OVERRIDE];
               entry_q.port_fwd <= reg_wdata[W2_PORT_LO +: 3];
            end
            OFS_ENTRY3: begin
               entry_q.forwarding_group_id <= reg_wdata[W3_FID_LO +: 7];
               entry_q.mac[47:32] <= reg_wdata[W3_MAC_LO +: 16];
            end
            OFS_ENTRY4: begin
               entry_q.mac[31:0] <= reg_wdata;
            end
            default: begin
               entry_q <= entry_q;
            end
         endcase
      end
   end

   // Read mux; reserved and unmapped bits read zero
   always_comb begin
      rd_word = REG_RESET;
      case (reg_addr)
         OFS_INDEX0: begin
            rd_word[W3_FID_LO +: 7] = key_q.forwarding_group_id;
            rd_word[W3_MAC_LO +: 16] = key_q.mac[47:32];
         end
         OFS_INDEX1: rd_word = key_q.mac[31:0];
         OFS_CTRL: begin
            rd_word[CTRL_OP_HI:CTRL_OP_LO] = op_q;
            rd_word[CTRL_DIRECT] = direct_q;
            rd_word[CTRL_ENTRY_OR_END] = entry_or_end_flag;
            rd_word[CTRL_VALID] = valid_q;
            rd_word[CTRL_GO] = go_done;
            rd_word[CTRL_TALLY_LO +: TW] = tally;
         end
         OFS_ENTRY1: begin
            rd_word[W1_STATIC] = entry_q.stat;
            rd_word[W1_SRC_DROP] = entry_q.src_drop;
            rd_word[W1_DST_DROP] = entry_q.dst_drop;
            rd_word[W1_AGE_LO +: 3] = entry_q.prio_age;
            rd_word[W1_SPAN_LO +: 3] = entry_q.span_id;
         end
         OFS_ENTRY2: begin
            rd_word[W2_OVERRIDE] = entry_q.override;
            rd_word[W2_PORT_LO +: 3] = entry_q.port_fwd;
         end
         OFS_ENTRY3: begin
            rd_word[W3_FID_LO +: 7] = entry_q.forwarding_group_id;
            rd_word[W3_MAC_LO +: 16] = entry_q.mac[47:32];
         end
         OFS_ENTRY4: rd_word = entry_q.mac[31:0];
         default: rd_word = REG_RESET;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= REG_RESET;
      end else if (reg_rd) begin
         reg_rdata <= rd_word;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   read_done_a: assert property (
      start_cmd && wr_op == OP_READ |-> ##[1:5] !go_done)
      else $error("read did not finish in time");
   miss_zero_a: assert property (
      $fell(go_done) && op_q == OP_READ && !valid_q |-> entry_q == '0)
      else $error("missed read left data nonzero");
   search_valid_a: assert property (
      start_cmd && wr_op == OP_SEARCH |=> !valid_q && go_done)
      else $error("search start kept valid");
   search_top_a: assert property (
      start_cmd && wr_op == OP_SEARCH |=> scan_ptr == '0)
      else $error("search not from first slot");
   tail_resume_a: assert property (
      state == ST_HOLD && tail_read && !abort_cmd |=> state != ST_HOLD
      && !valid_q)
      else $error("word four read did not resume");
   abort_stop_a: assert property (
      abort_cmd |=> state == ST_IDLE && !go_done)
      else $error("abort did not stop search");
   hold_busy_a: assert property (
      state == ST_HOLD |-> valid_q && go_done)
      else $error("held entry without busy and valid");
   combo_flag_a: assert property (
      $rose(valid_q) || $fell(go_done) |-> entry_or_end_flag)
      else $error("combined flag missed event");
   static_only_a: assert property (
      mem_we |-> entry_q.stat && op_q == OP_WRITE)
      else $error("non-static entry written");
   skip_dead_a: assert property (
      state == ST_SCAN && !cur_live && !abort_cmd |=> !valid_q)
      else $error("dead slot shown as valid");
   found_count_a: assert property (
      $rose(valid_q) && op_q == OP_SEARCH |-> tally == $past(tally) + TW'(1))
      else $error("tally missed a found entry");

   read_hit_c: cover property (
      $fell(go_done) && op_q == OP_READ && valid_q);
   write_done_c: cover property (mem_we);
   search_end_c: cover property (
      $fell(go_done) && op_q == OP_SEARCH && tally != '0);
   abort_c: cover property (abort_cmd && state == ST_HOLD);
endmodule
`default_nettype wire

// File: mlt_pkg.sv
/*
 * Shared definitions for the lookup table access engine: register
 * offsets, control and entry field positions, operation codes and
 * the entry and key layouts.
 * Assumes a single core clock and a word-wide register port.
 */
`default_nettype none
package mlt_pkg;
   // Register offsets
   localparam logic [15:0] OFS_INDEX0 = 16'h0410;
   localparam logic [15:0] OFS_INDEX1 = 16'h0414;
   localparam logic [15:0] OFS_CTRL = 16'h0418;
   localparam logic [15:0] OFS_ENTRY1 = 16'h0420;
   localparam logic [15:0] OFS_ENTRY2 = 16'h0424;
   localparam logic [15:0] OFS_ENTRY3 = 16'h0428;
   localparam logic [15:0] OFS_ENTRY4 = 16'h042C;
   // Table shape
   localparam int TABLE_DEPTH = 4096;
   localparam int BUCKET_WAYS = 4;
   // Control register fields
   localparam int CTRL_OP_LO = 0;
   localparam int CTRL_OP_HI = 1;
   localparam int CTRL_DIRECT = 2;
   localparam int CTRL_ENTRY_OR_END = 5;
   localparam int CTRL_VALID = 6;
   localparam int CTRL_GO = 7;
   localparam int CTRL_TALLY_LO = 16;
   // Operation codes
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_SEARCH = 2'h3;
   // Entry word fields; index 0 shares the word three layout
   localparam int W1_STATIC = 31;
   localparam int W1_SRC_DROP = 30;
   localparam int W1_DST_DROP = 29;
   localparam int W1_AGE_LO = 26;
   localparam int W1_SPAN_LO = 0;
   localparam int W2_OVERRIDE = 31;
   localparam int W2_PORT_LO = 0;
   localparam int W3_FID_LO = 16;
   localparam int W3_MAC_LO = 0;
   // Reset value of read data and every data register; control reads 0x20 after reset
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [6:0] forwarding_group_id;
      logic [47:0] mac;
   } mlt_key_t;

   typedef struct packed {
      logic stat;
      logic src_drop;
      logic dst_drop;
      logic [2:0] prio_age;
      logic [2:0] span_id;
      logic override;
      logic [2:0] port_fwd;
      logic [6:0] forwarding_group_id;
      logic [47:0] mac;
   } mlt_entry_t;

   // Static entries always live; dynamic ones only while aged above zero
   function automatic logic mlt_live(input mlt_entry_t e);
      return e.stat | (e.prio_age != 3'h0);
   endfunction
endpackage
`default_nettype wire

// File: mlt_store.sv
/*
 * Entry storage: flip-flop array with one write port and one
 * combinational read port, both addressed by index.
 * Assumes the engine never reads and writes the same slot in one
 * cycle with a need for the new value.
 */
`timescale 1ns/10ps
`default_nettype none
module mlt_store #(
   parameter int WIDTH = 68,
   parameter int DEPTH = 4096,
   parameter int AW = 12
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Write side
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Read side
   input wire logic [AW-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Cleared on reset so that no slot looks live afterwards
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   assign rd_data = mem[rd_idx];
endmodule
`default_nettype wire

// File: mlt_hash.sv
/*
 * Bucket hash: folds the address, and the group id when asked,
 * into a bucket index by exclusive-or.
 * Assumes a purely combinational use by the access engine.
 */
`timescale 1ns/10ps
`default_nettype none
module mlt_hash import mlt_pkg::*; #(
   parameter int OUT_W = 10
) (
   // Lookup key
   input var mlt_key_t key,
   input wire logic use_fid,
   // Bucket index
   output logic [OUT_W-1:0] bucket
);
   always_comb begin
      bucket = '0;
      for (int i = 0; i < 48; i++) begin
         bucket[i % OUT_W] = bucket[i % OUT_W] ^ key.mac[i];
      end
      for (int j = 0; j < 7; j++) begin
         bucket[j % OUT_W] = bucket[j % OUT_W] ^ (use_fid & key.forwarding_group_id[j]);
      end
   end
endmodule
`default_nettype wire

// File: tb_mac_lookup_table_access.sv
/*
 * Self-checking bench for the lookup table access engine: drives the
 * register port directly and checks reads, writes and the search.
 * Assumes mlt_pkg and the design files are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_mac_lookup_table_access;
   import mlt_pkg::*;
   // Short table so that a full scan stays brief
   localparam int DEPTH = 64;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic hash_use_fid = 1'b1;
   logic [31:0] d;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;

   mlt_access #(.DEPTH(DEPTH)) dut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .hash_use_fid(hash_use_fid)
   );

   always #10 core_clk = ~core_clk;

   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Whole run needs a few hundred cycles; this is a generous ceiling
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail = n_fail + 1;
         test_done();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // Stops on done, or on a found entry while searching
   task automatic poll(input logic srch);
      for (int i = 0; i < 300; i++) begin
         rd(OFS_CTRL);
         if (d[CTRL_GO] !== 1'b1 || (srch && d[CTRL_VALID] === 1'b1)) return;
      end
      chk("poll bound", 32'h1, 32'h0);
   endtask

   task automatic op(input logic [6:0] f, input logic [47:0] m,
                     input logic [7:0] c);
      wr(OFS_INDEX0, {9'h000, f, m[47:32]});
      wr(OFS_INDEX1, m[31:0]);
      wr(OFS_CTRL, {24'h000000, c});
      poll(1'b0);
   endtask

   task automatic load(input logic [31:0] w1, w3, w4);
      wr(OFS_ENTRY1, w1);
      wr(OFS_ENTRY2, 32'h8000_0005);
      wr(OFS_ENTRY3, w3);
      wr(OFS_ENTRY4, w4);
   endtask

   task automatic t_reset();
      rd(OFS_CTRL);
      chk("ctrl reset", d, 32'h0000_0020);
      rd(OFS_ENTRY1);
      chk("word1 reset", d, 32'h0);
      rd(16'h0440);
      chk("unmapped", d, 32'h0);
      // Code 00 with go set starts nothing
      wr(OFS_CTRL, 32'h0000_0080);
      rd(OFS_CTRL);
      chk("no-op go", d, 32'h0000_0020);
   endtask

   // Upper address bits are junk: with the 64-entry table only bits 5:0 pick the slot
   task automatic t_direct();
      load(32'hFFFF_FFFF, 32'h0012_ABCD, 32'h1234_5678);
      op(7'h00, 48'hFFFF_FFFF_F005, 8'h85);
      chk("wr done", d[7:0], 8'h25);
      op(7'h00, 48'h0000_0000_0005, 8'h86);
      chk("rd flags", d[7:5], 3'b011);
      rd(OFS_ENTRY1);
      chk("word1", d, 32'hFC00_0007);
      rd(OFS_ENTRY2);
      chk("word2", d, 32'h8000_0005);
      rd(OFS_ENTRY3);
      chk("word3", d, 32'h0012_ABCD);
      rd(OFS_ENTRY4);
      chk("word4", d, 32'h1234_5678);
   endtask

   // A dynamic entry written by the host must not land
   task automatic t_miss();
      load(32'h0400_0000, 32'h0000_0001, 32'h0000_0009);
      op(7'h00, 48'h9, 8'h85);
      op(7'h00, 48'h9, 8'h86);
      chk("miss flags", d[7:5], 3'b001);
      rd(OFS_ENTRY4);
      chk("miss word4", d, 32'h0);
   endtask

   task automatic t_hash();
      op(7'h21, 48'hA1B2_C3D4_E5F6, 8'h82);
      chk("pre read", d[7:5], 3'b001);
      load(32'h9400_0002, 32'h0021_A1B2, 32'hC3D4_E5F6);
      op(7'h21, 48'hA1B2_C3D4_E5F6, 8'h81);
      op(7'h21, 48'hA1B2_C3D4_E5F6, 8'h82);
      chk("hash hit", d[CTRL_VALID], 1'b1);
      rd(OFS_ENTRY1);
      chk("hash word1", d, 32'h9400_0002);
      op(7'h22, 48'hA1B2_C3D4_E5F6, 8'h82);
      chk("fid miss", d[CTRL_VALID], 1'b0);
   endtask

   task automatic t_search();
      int found;
      found = 0;
      wr(OFS_CTRL, 32'h0000_0083);
      for (int n = 0; n < 4; n++) begin
         poll(1'b1);
         if (d[CTRL_GO] !== 1'b1) break;
         chk("entry flag", d[CTRL_ENTRY_OR_END], 1'b1);
         rd(OFS_ENTRY1);
         chk("found static", d[W1_STATIC], 1'b1);
         rd(OFS_ENTRY2);
         rd(OFS_ENTRY3);
         rd(OFS_ENTRY4);
         found++;
      end
      chk("found", found, 2);
      chk("end go", d[7:5], 3'b001);
      chk("tally", d[28:16], 13'h0002);
      rd(OFS_ENTRY1);
      chk("end word1", d, 32'h0);
      rd(OFS_ENTRY4);
      chk("end word4", d, 32'h0);
   endtask

   task automatic t_abort();
      wr(OFS_CTRL, 32'h0000_0083);
      wr(OFS_CTRL, 32'h0000_0003);
      rd(OFS_CTRL);
      chk("abort go", d[CTRL_GO], 1'b0);
   endtask

   // With VLAN off the group id takes no part in hash or match
   task automatic t_nofid();
      hash_use_fid = 1'b0;
      load(32'h8000_0000, 32'h0021_0000, 32'h0000_0777);
      op(7'h21, 48'h0000_0000_0777, 8'h81);
      op(7'h5A, 48'h0000_0000_0777, 8'h82);
      chk("no fid hit", d[CTRL_VALID], 1'b1);
      hash_use_fid = 1'b1;
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_direct();
      t_miss();
      t_hash();
      t_search();
      t_abort();
      t_nofid();
      test_done();
   end
endmodule
`default_nettype wire
